// ==== rtl/coc_map.vh ====
/*
 Register offsets, field positions and reset values of the output control
 block. Assumes inclusion by bare name from the rtl files.
*/
`ifndef COC_MAP_VH
`define COC_MAP_VH

// Register word addresses
`define COC_ADDR_CONFIG    8'h00
`define COC_ADDR_STATE     8'h01
`define COC_ADDR_MANUAL    8'h02
`define COC_ADDR_STATUS    8'h03
`define COC_ADDR_ENABLE0   8'h04
`define COC_ADDR_ENABLE1   8'h05
`define COC_ADDR_ACTIVE0   8'h06
`define COC_ADDR_ACTIVE1   8'h07
`define COC_ADDR_TYPE      8'h08
// Range table: 0x40 + ch*0x60 + entry*3 + word
// Starts low so all 32 entries of both channels fit the 8-bit address
`define COC_ADDR_TABLE     8'h40
`define COC_TABLE_CH_SPAN  8'h60

// Config fields
`define COC_MODE_LSB       0
`define COC_COMBINE_LSB    8
`define COC_MODE_RANGE     8'h00
`define COC_MODE_COMPARE   8'h01
`define COC_COMB_OR        8'h00
`define COC_COMB_AND       8'h01
`define COC_CONFIG_RESET   16'h0000

// Status bits
`define COC_STAT_CFG_ERR   0

`endif

// ==== rtl/coc_range_mem.v ====
/*
 Range table memory: one word per location, registered read data.
 Assumes one clock and a single read and write port.
*/
module coc_range_mem #(
    parameter AW = 8,
    parameter DW = 32
) (
    // Clock
    input wire sys_clk,
    // Write side
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    // Read side
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ==== rtl/coc_compare.v ====
/*
 Range hit test for one counter value against one range.
 Assumes limits and value share the signedness given by is_linear.
*/
module coc_compare (
    // Operands
    input wire is_linear,
    input wire [31:0] value,
    input wire [31:0] low_limit,
    input wire [31:0] up_limit,
    // Result
    output wire hit
);
    wire [31:0] flip;
    wire [31:0] v;
    wire [31:0] lo;
    wire [31:0] hi;
    wire ge_lo;
    wire le_hi;

    // Offset binary turns signed order into unsigned order
    assign flip = is_linear ? 32'h80000000 : 32'h00000000;
    assign v = value ^ flip;
    assign lo = low_limit ^ flip;
    assign hi = up_limit ^ flip;
    assign ge_lo = (v >= lo);
    assign le_hi = (v <= hi);
    // Inclusive limits; circular ranges wrap when upper lies below lower, linear ones never hit
    assign hit = (is_linear || lo <= hi) ? (ge_lo && le_hi)
                                          : (ge_lo || le_hi);
endmodule

// ==== rtl/coc_output_ctrl.v ====
/*
 Output control of a two counter unit: range evaluation, unit output
 pattern, manual override and status words over a plain register port.
 Assumes counter values arrive from counting logic on sys_clk.
*/
// Chosen here: the address-and-strobe port and the register offsets.
// Operation
// (RULE_01) Thirty two outputs: two external, thirty soft
// (RULE_02) Up to 32 ranges per counter
// (RULE_03) Comparison mode entries, crossing direction based; code ignores entries, bits 0/1 follow each counter's last change direction
// (RULE_04) One mode for both counters
// (RULE_05) Config low byte selects mode
// (RULE_06) Config high byte selects OR/AND combine
// (RULE_07) Unit pattern drives outputs, bits 0,1 external
// (RULE_08) Packed 32-bit output status word
// (RULE_09) Each output readable as single bit
// (RULE_10) Outputs may be driven manually
// (RULE_11) Ranges work for signed or unsigned counters
// (RULE_12) Overlapping active ranges OR their patterns
// (RULE_13) Active when lower <= value <= upper
// (RULE_14) Circular ranges may wrap through rollover
// (RULE_15) Disabled ranges ignored, disabled by default
// (RULE_16) Bad selector values flag configuration error
`include "coc_map.vh"

module coc_output_ctrl #(
    parameter NUM_RANGES = 32
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Counter values
    input wire [31:0] count_ch0,
    input wire [31:0] count_ch1,
    // Outputs
    output wire external_output_zero,
    output wire external_output_one,
    output wire [31:0] output_state_bits,
    output wire config_error
);
    localparam ST_ADDR = 2'd0;
    localparam ST_DATA = 2'd1;
    localparam ST_DONE = 2'd2;

    reg [15:0] output_control_config_r;
    reg [31:0] manual_value_r;
    reg [31:0] manual_select_r;
    reg [31:0] enable_r [0:1];
    reg [1:0] linear_r;
    reg [31:0] active_r [0:1];
    reg [31:0] active_nxt [0:1];
    reg [31:0] acc_r [0:1];
    reg [31:0] chan_pat_r [0:1];
    reg [31:0] unit_pat_r;
    reg [1:0] cmp_dir_r;
    reg [31:0] prev_r [0:1];
    reg [1:0] state_r;
    reg [4:0] idx_r;
    reg [1:0] word_r;
    reg ch_r;
    reg [31:0] low_r;
    reg [31:0] up_r;
    reg [31:0] val_r;
    reg [31:0] auto_pat;

    wire [7:0] mode_sel;
    wire [7:0] comb_sel;
    wire mode_bad;
    wire comb_bad;
    wire tbl_hit;
    wire [7:0] tbl_addr;
    wire [7:0] scan_addr;
    wire [31:0] mem_rdata;
    wire range_hit;
    wire [31:0] final_pat;
    wire scan_take;

    // Table address of a channel, entry and word
    function [7:0] tbl_index;
        input ch;
        input [4:0] entry;
        input [1:0] word;
        begin
            tbl_index = (ch ? `COC_TABLE_CH_SPAN : 8'h00)
                + {1'b0, entry, 2'b00} - {3'b000, entry}
                + {6'b000000, word};
        end
    endfunction

    // Register decode of channel-indexed words
    function is_table;
        input [7:0] addr;
        begin
            is_table = (addr >= `COC_ADDR_TABLE);
        end
    endfunction

    // One-hot mask of a range entry
    function [31:0] entry_mask;
        input [4:0] entry;
        begin
            entry_mask = 32'h00000001 << entry;
        end
    endfunction

    assign mode_sel = output_control_config_r[`COC_MODE_LSB +: 8];
    assign comb_sel = output_control_config_r[`COC_COMBINE_LSB +: 8];
    // see (RULE_16)
    assign mode_bad = (mode_sel != `COC_MODE_RANGE) &&
                      (mode_sel != `COC_MODE_COMPARE);
    assign comb_bad = (comb_sel != `COC_COMB_OR) &&
                      (comb_sel != `COC_COMB_AND);
    assign config_error = mode_bad | comb_bad;

    assign tbl_hit = reg_wr && is_table(reg_addr);
    assign tbl_addr = reg_addr - `COC_ADDR_TABLE;
    assign scan_addr = tbl_index(ch_r, idx_r, word_r);
    // Entry counts only when enabled and hit
    assign scan_take = range_hit && (|(enable_r[ch_r] & entry_mask(idx_r)));

    // Table writes use the write port, the scan the read port; scan reads only
    coc_range_mem #(
        .AW(8),
        .DW(32)
    ) u_mem (
        .sys_clk(sys_clk),
        .wr_en(tbl_hit),
        .wr_addr(tbl_addr),
        .wr_data(reg_wdata),
        .rd_addr(scan_addr),
        .rd_data(mem_rdata)
    );

    // see (RULE_11) (RULE_13) (RULE_14)
    coc_compare u_cmp (
        .is_linear(linear_r[ch_r]),
        .value(val_r),
        .low_limit(low_r),
        .up_limit(up_r),
        .hit(range_hit)
    );

    // Register writes
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            output_control_config_r <= `COC_CONFIG_RESET;
            manual_value_r <= 32'h00000000;
            manual_select_r <= 32'h00000000;
            enable_r[0] <= 32'h00000000; // see (RULE_15)
            enable_r[1] <= 32'h00000000;
            linear_r <= 2'b00;
        end else if (reg_wr) begin
            case (reg_addr)
                `COC_ADDR_CONFIG: begin
                    output_control_config_r <= reg_wdata[15:0];
                end
                `COC_ADDR_MANUAL: begin
                    manual_value_r <= reg_wdata;
                end
                `COC_ADDR_STATUS: begin
                    manual_select_r <= reg_wdata;
                end
                `COC_ADDR_ENABLE0: begin
                    enable_r[0] <= reg_wdata;
                end
                `COC_ADDR_ENABLE1: begin
                    enable_r[1] <= reg_wdata;
                end
                `COC_ADDR_TYPE: begin
                    linear_r <= reg_wdata[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Range scan: three words per entry, one channel after the other.
    // A full sweep takes about 2*32*4 cycles, traded for one comparator.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= ST_ADDR;
            idx_r <= 5'd0;
            word_r <= 2'd0;
            ch_r <= 1'b0;
            low_r <= 32'h00000000;
            up_r <= 32'h00000000;
            val_r <= 32'h00000000;
            acc_r[0] <= 32'h00000000;
            acc_r[1] <= 32'h00000000;
            active_r[0] <= 32'h00000000;
            active_r[1] <= 32'h00000000;
            active_nxt[0] <= 32'h00000000;
            active_nxt[1] <= 32'h00000000;
            chan_pat_r[0] <= 32'h00000000;
            chan_pat_r[1] <= 32'h00000000;
        end else begin
            case (state_r)
                ST_ADDR: begin
                    val_r <= ch_r ? count_ch1 : count_ch0;
                    word_r <= 2'd1;
                    state_r <= ST_DATA;
                end
                ST_DATA: begin
                    if (word_r == 2'd1) begin
                        low_r <= mem_rdata;
                        word_r <= 2'd2;
                    end else begin
                        up_r <= mem_rdata;
                        word_r <= 2'd0;
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Pattern word now on the read data
                    if (scan_take) begin
                        // see (RULE_12) (RULE_15)
                        acc_r[ch_r] <= acc_r[ch_r] | mem_rdata;
                        active_nxt[ch_r][idx_r] <= 1'b1;
                    end else begin
                        active_nxt[ch_r][idx_r] <= 1'b0;
                    end
                    state_r <= ST_ADDR;
                    // see (RULE_02)
                    if (idx_r == NUM_RANGES - 1) begin
                        idx_r <= 5'd0;
                        ch_r <= ~ch_r;
                        acc_r[ch_r] <= 32'h00000000;
                        chan_pat_r[ch_r] <= acc_r[ch_r] |
                            (scan_take ? mem_rdata : 32'h00000000);
                        // Last entry folded in here, not a sweep late
                        active_r[ch_r] <= (active_nxt[ch_r] &
                            ~entry_mask(idx_r)) |
                            (scan_take ? entry_mask(idx_r) : 32'h00000000);
                    end else begin
                        idx_r <= idx_r + 5'd1;
                    end
                end
                default: begin
                    state_r <= ST_ADDR;
                end
            endcase
        end
    end

    // Comparison mode kept minimal: any upward change of the value
    // raises the channel flag, any downward change clears it.
    // see (RULE_03)
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cmp_dir_r <= 2'b00;
            prev_r[0] <= 32'h00000000;
            prev_r[1] <= 32'h00000000;
        end else begin
            prev_r[0] <= count_ch0;
            prev_r[1] <= count_ch1;
            if (count_ch0 != prev_r[0]) begin
                cmp_dir_r[0] <= (count_ch0 > prev_r[0]);
            end
            if (count_ch1 != prev_r[1]) begin
                cmp_dir_r[1] <= (count_ch1 > prev_r[1]);
            end
        end
    end

    // Bad config forces automatic outputs off rather than a guess
    // see (RULE_04) (RULE_05) (RULE_06)
    always @* begin
        auto_pat = 32'h00000000;
        if (!config_error) begin
            case (mode_sel)
                `COC_MODE_COMPARE: begin
                    auto_pat = {30'h0, cmp_dir_r};
                end
                default: begin
                    if (comb_sel == `COC_COMB_AND) begin
                        auto_pat = chan_pat_r[0] & chan_pat_r[1];
                    end else begin
                        auto_pat = chan_pat_r[0] | chan_pat_r[1];
                    end
                end
            endcase
        end
    end
    // see (RULE_10)
    assign final_pat = (manual_select_r & manual_value_r) |
                       (~manual_select_r & auto_pat);

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            unit_pat_r <= 32'h00000000;
        end else begin
            unit_pat_r <= final_pat;
        end
    end

    // see (RULE_01) (RULE_07)
    assign external_output_zero = unit_pat_r[0];
    assign external_output_one = unit_pat_r[1];
    // see (RULE_09)
    assign output_state_bits = unit_pat_r;

    // Register reads, answer one cycle later
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `COC_ADDR_CONFIG: begin
                    reg_rdata <= {16'h0000, output_control_config_r};
                end
                `COC_ADDR_STATE: begin
                    reg_rdata <= unit_pat_r; // see (RULE_08)
                end
                `COC_ADDR_MANUAL: begin
                    reg_rdata <= manual_value_r;
                end
                `COC_ADDR_STATUS: begin
                    reg_rdata <= manual_select_r;
                end
                `COC_ADDR_ENABLE0: begin
                    reg_rdata <= enable_r[0];
                end
                `COC_ADDR_ENABLE1: begin
                    reg_rdata <= enable_r[1];
                end
                `COC_ADDR_ACTIVE0: begin
                    reg_rdata <= active_r[0];
                end
                `COC_ADDR_ACTIVE1: begin
                    reg_rdata <= active_r[1];
                end
                `COC_ADDR_TYPE: begin
                    reg_rdata <= {29'h0, config_error, linear_r};
                end
                default: begin
                    // Table is write only; unmapped reads zero
                    reg_rdata <= 32'h00000000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule

// ==== tb/coc_output_ctrl_assertions.sv ====
/*
 Checker for the output control block, bound to its top module ports.
 Assumes one clock domain with a synchronous active low reset.
*/
module coc_checker #(
    parameter NUM_RANGES = 32
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Outputs
    input wire external_output_zero,
    input wire external_output_one,
    input wire [31:0] output_state_bits,
    input wire config_error
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ext_zero_tied: assert property (
        external_output_zero == output_state_bits[0])
        else $error("external output zero differs from status bit");
    a_ext_one_tied: assert property (
        external_output_one == output_state_bits[1])
        else $error("external output one differs from status bit");
    a_reset_all_off: assert property (
        $rose(rst_n) |-> output_state_bits == 32'h0 && !config_error)
        else $error("outputs not off after reset");
    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_unmapped_reads_zero: assert property (
        reg_rd && reg_addr > 8'h08 |=> reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    // Stable status on both sides keeps the sampling moment harmless
    a_state_word_read: assert property (
        reg_rd && reg_addr == 8'h01 && $stable(output_state_bits)
        ##1 $stable(output_state_bits) |-> reg_rdata == output_state_bits)
        else $error("state word read differs from status bits");
    a_bad_cfg_flag: assert property (
        reg_wr && reg_addr == 8'h00 &&
        (reg_wdata[7:0] > 8'h01 || reg_wdata[15:8] > 8'h01) |=> config_error)
        else $error("bad selector not flagged");
    a_good_cfg_clear: assert property (
        reg_wr && reg_addr == 8'h00 &&
        reg_wdata[7:0] <= 8'h01 && reg_wdata[15:8] <= 8'h01 |=> !config_error)
        else $error("legal selector flagged");
    a_err_readback: assert property (
        reg_rd && reg_addr == 8'h08 |=> reg_rdata[2] == $past(config_error))
        else $error("error bit readback wrong");
endmodule

bind coc_output_ctrl coc_checker #(.NUM_RANGES(NUM_RANGES)) coc_checker_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_output_zero(external_output_zero),
    .external_output_one(external_output_one),
    .output_state_bits(output_state_bits), .config_error(config_error));

// ==== tb/coc_host_model.sv ====
/*
 Host controller model: writes settings, reads status words.
 Assumes single cycle strobes answered one cycle later.
*/
module coc_host_model (
    // Clock
    input wire sys_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Callers pass only 00/01 selectors unless refusal is meant
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// ==== tb/tb_top.sv ====
/*
 Self-checking bench of the output control block.
 Assumes the host model drives the register port.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] count_ch0 = 32'h0;
    logic [31:0] count_ch1 = 32'h0;
    wire [7:0] reg_addr;
    wire [31:0] reg_wdata, reg_rdata, output_state_bits;
    wire reg_wr, reg_rd, external_output_zero, external_output_one;
    wire config_error;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h55;
    logic [31:0] lo[2][4], up[2][4], pat[2][4];
    logic [3:0] en[2];
    logic [1:0] lin;
    logic comb, bad;
    logic [31:0] rd_v, v;
    logic [15:0] cfgs[5] = '{16'h0002, 16'h0200, 16'h0101, 16'h0001, 16'h0};

    coc_output_ctrl coc_output_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_ch0(count_ch0),
        .count_ch1(count_ch1), .external_output_zero(external_output_zero),
        .external_output_one(external_output_one),
        .output_state_bits(output_state_bits), .config_error(config_error));
    coc_host_model coc_host_model_i (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Small values around zero: signed and unsigned readings differ
    function automatic logic [31:0] sm();
        logic [31:0] r = rnd();
        return {28'h0, r[3:0]} - 32'h8;
    endfunction
    function automatic logic hit(logic l, logic [31:0] x, a, b);
        if (l)
            return $signed(a) <= $signed(x) && $signed(x) <= $signed(b);
        if (a <= b)
            return a <= x && x <= b;
        return x >= a || x <= b;
    endfunction
    function automatic logic [31:0] expect_pat();
        logic [31:0] p[2];
        for (int c = 0; c < 2; c++) begin
            p[c] = 32'h0;
            for (int k = 0; k < 4; k++)
                if (en[c][k] && hit(lin[c], c ? count_ch1 : count_ch0,
                    lo[c][k], up[c][k]))
                    p[c] |= pat[c][k];
        end
        return comb ? p[0] & p[1] : p[0] | p[1];
    endfunction
    task automatic check(input logic [31:0] seen, exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Entries 0 to 2 and the last one, 31, of each channel
    task automatic range_round();
        logic [31:0] m;
        logic [31:0] act[2];
        int e;
        comb = rnd() % 2;
        lin = rnd() % 4;
        @(posedge sys_clk);
        count_ch0 <= sm();
        count_ch1 <= sm();
        for (int c = 0; c < 2; c++) begin
            m = 32'h0;
            en[c] = rnd() % 16;
            for (int k = 0; k < 4; k++) begin
                e = k < 3 ? k : 31;
                m[e] = en[c][k];
                lo[c][k] = sm();
                up[c][k] = sm();
                pat[c][k] = rnd();
                coc_host_model_i.wr(8'(64 + c * 96 + e * 3), lo[c][k]);
                coc_host_model_i.wr(8'(65 + c * 96 + e * 3), up[c][k]);
                coc_host_model_i.wr(8'(66 + c * 96 + e * 3), pat[c][k]);
            end
            coc_host_model_i.wr(8'(4 + c), m);
        end
        coc_host_model_i.wr(8'h08, {30'h0, lin});
        coc_host_model_i.wr(8'h00, {23'h0, comb, 8'h00});
        repeat (600) @(posedge sys_clk);
        v = expect_pat();
        coc_host_model_i.rd(8'h01, rd_v);
        check(rd_v, v, "state word");
        check(output_state_bits, v, "status bits");
        check({30'h0, external_output_one, external_output_zero},
            {30'h0, v[1:0]}, "external outputs");
        for (int c = 0; c < 2; c++) begin
            act[c] = 32'h0;
            for (int k = 0; k < 4; k++)
                act[c][k < 3 ? k : 31] = en[c][k] && hit(lin[c],
                    c ? count_ch1 : count_ch0, lo[c][k], up[c][k]);
            coc_host_model_i.rd(8'(6 + c), rd_v);
            check(rd_v, act[c], "active ranges");
        end
    endtask

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 9; a++) begin
            coc_host_model_i.rd(8'(a), rd_v);
            check(rd_v, 32'h0, "reset value");
        end
        $display("test reset done");
        for (int i = 0; i < 6; i++)
            range_round();
        $display("test range done");
        coc_host_model_i.wr(8'h03, 32'hffffffff);
        v = rnd();
        coc_host_model_i.wr(8'h02, v);
        repeat (600) @(posedge sys_clk);
        check(output_state_bits, v, "manual drive");
        coc_host_model_i.wr(8'h03, 32'h0);
        $display("test manual done");
        for (int i = 0; i < 5; i++) begin
            bad = cfgs[i][7:0] > 8'h01 || cfgs[i][15:8] > 8'h01;
            coc_host_model_i.wr(8'h00, {16'h0, cfgs[i]});
            #1;
            check(32'(config_error), 32'(bad), "cfg flag");
            coc_host_model_i.rd(8'h08, rd_v);
            check(32'(rd_v[2]), 32'(bad), "cfg bit");
            if (bad) begin
                repeat (600) @(posedge sys_clk);
                check(output_state_bits, 32'h0, "bad cfg off");
            end
        end
        $display("test config done");
        // Comparison mode: each channel bit follows its last direction
        coc_host_model_i.wr(8'h00, 32'h0001);
        @(posedge sys_clk);
        count_ch0 <= count_ch0 + 32'h1;
        count_ch1 <= count_ch1 - 32'h1;
        repeat (4) @(posedge sys_clk);
        check(output_state_bits, 32'h1, "compare up down");
        count_ch0 <= count_ch0 - 32'h1;
        count_ch1 <= count_ch1 + 32'h1;
        repeat (4) @(posedge sys_clk);
        check(output_state_bits, 32'h2, "compare down up");
        coc_host_model_i.wr(8'h00, 32'h0);
        $display("test compare done");
        coc_host_model_i.wr(8'h20, rnd());
        coc_host_model_i.rd(8'h20, rd_v);
        check(rd_v, 32'h0, "unmapped");
        $display("test unmapped done");
        give_verdict();
    end
endmodule
